// *** hdl/ata_maint_pkg.sv ***
// Register map, task-file layout, opcodes and the handler state record
package ata_maint_pkg;

	// Byte offsets on the register bus
	localparam logic [7:0] OFF_DATA      = 8'h00;
	localparam logic [7:0] OFF_FEATURE   = 8'h04;
	localparam logic [7:0] OFF_SECCNT    = 8'h08;
	localparam logic [7:0] OFF_SECNUM    = 8'h0c;
	localparam logic [7:0] OFF_CYL_LO    = 8'h10;
	localparam logic [7:0] OFF_CYL_HI    = 8'h14;
	localparam logic [7:0] OFF_DEVHEAD   = 8'h18;
	localparam logic [7:0] OFF_COMMAND   = 8'h1c;
	localparam logic [7:0] OFF_DEVCTL    = 8'h20;
	localparam logic [7:0] OFF_CONFIG    = 8'h24;
	localparam logic [7:0] OFF_IRQ_STAT  = 8'h28;
	localparam logic [7:0] OFF_IRQ_MASK  = 8'h2c;
	localparam logic [7:0] OFF_SEC_LEFT  = 8'h30;

	// Task-file slots, index = offset / 4 - 1
	localparam int TF_FEATURE = 0;
	localparam int TF_SECCNT  = 1;
	localparam int TF_SECNUM  = 2;
	localparam int TF_SLOTS   = 5;

	// Command opcodes and the download subcommand
	localparam logic [7:0] OP_DOWNLOAD  = 8'h92;
	localparam logic [7:0] OP_DIAG      = 8'h90;
	localparam logic [7:0] OP_FLUSH     = 8'he7;
	localparam logic [7:0] OP_FLUSH_EXT = 8'hea;
	localparam logic [7:0] SUBCMD_SAVE  = 8'h07;

	// Error register bits
	localparam int ERR_CRC = 7;
	localparam int ERR_UNC = 6;
	localparam int ERR_IDN = 4;
	localparam int ERR_ABT = 2;
	localparam int ERR_TON = 1;
	localparam int ERR_AMN = 0;

	// Status register bits
	localparam int ST_BSY = 7;
	localparam int ST_RDY = 6;
	localparam int ST_DF  = 5;
	localparam int ST_DSC = 4;
	localparam int ST_DRQ = 3;
	localparam int ST_COR = 2;
	localparam int ST_IDX = 1;
	localparam int ST_ERR = 0;

	// Control bits, interrupt events, bus responses
	localparam int         DEVCTL_HOB   = 7;
	localparam int         CFG_SPIN_DIS = 0;
	localparam int         EV_DONE      = 0;
	localparam int         EV_DRQ       = 1;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	// 512-byte sector carried as 32-bit words
	localparam logic [6:0] WORD_LAST = 7'h7f;

	typedef enum logic [2:0] {
		PH_IDLE   = 3'h0,
		PH_XFER   = 3'h1,
		PH_RELOAD = 3'h3,
		PH_FLUSH  = 3'h2,
		PH_DIAG   = 3'h6
	} phase_type;

	typedef struct packed {
		logic                aw_got;
		logic [7:0]          aw_addr;
		logic                w_got;
		logic [31:0]         w_data;
		logic [3:0]          w_strb;
		logic                awready;
		logic                wready;
		logic                bvalid;
		logic [1:0]          bresp;
		logic                arready;
		logic                rvalid;
		logic [31:0]         rdata;
		logic [1:0]          rresp;
		logic [4:0][7:0]     tf_cur;
		logic [4:0][7:0]     tf_prev;
		logic [7:0]          devhead;
		logic                hob;
		logic                spin_dis;
		logic [7:0]          err;
		logic                err_flag;
		logic                bsy;
		logic                drq;
		phase_type           phase;
		logic [15:0]         sec_left;
		logic [6:0]          word_cnt;
		logic [1:0]          irq_stat;
		logic [1:0]          irq_mask;
		logic                irq;
		logic                diag_start;
		logic                flush_req;
		logic                reload_start;
		logic                dasp;
		logic                spin_down;
		logic [31:0]         ucode_data;
		logic                ucode_valid;
		logic [2:0]          slv_sync;
		logic                slv_stable;
		logic                slave_lost;
		logic                slave_seen;
	} state_type;

endpackage : ata_maint_pkg

// *** hdl/ata_maint_command_handler.sv ***
// Drive-side handler for microcode download, diagnostic and cache flush commands
`timescale 1ns/100ps
`default_nettype none

module ata_maint_command_handler (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst_n,
	// AXI4-Lite write channels
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic             o_bvalid,
	output logic [1:0]       o_bresp,
	input  wire logic        i_bready,
	// AXI4-Lite read channels
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic             o_rvalid,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	input  wire logic        i_rready,
	// Interrupt
	output logic             o_irq,
	// Drive services
	input  wire logic        i_security_locked,
	output logic             o_diag_start,
	input  wire logic        i_diag_done,
	input  wire logic [7:0]  i_diag_code,
	output logic             o_flush_req,
	input  wire logic        i_flush_done,
	input  wire logic        i_flush_fail,
	// Microcode path
	output logic [31:0]      o_ucode_data,
	output logic             o_ucode_valid,
	input  wire logic        i_reload_requested,
	output logic             o_reload_start,
	input  wire logic        i_reload_done,
	input  wire logic        i_reload_ok,
	output logic             o_spin_down,
	// Second-device presence
	output logic             o_dasp_handshake,
	input  wire logic        i_slave_present,
	output logic             o_slave_seen
);

	ata_maint_pkg::state_type s;
	ata_maint_pkg::state_type nxt;
	logic                     wr_fire;
	logic                     cmd_go;
	logic                     data_go;
	logic [15:0]              dl_len;
	logic [1:0]               ev;

	function automatic int tf_index(input logic [7:0] a);
		tf_index = int'(a[7:2]) - 1;
	endfunction : tf_index

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a[1:0] == 2'h0) && (a <= ata_maint_pkg::OFF_SEC_LEFT);
	endfunction : addr_ok

	function automatic logic [31:0] read_value(input ata_maint_pkg::state_type st, input logic [7:0] a);
		read_value = 32'h0;
		case (a)
			ata_maint_pkg::OFF_FEATURE: read_value[7:0] = st.err;
			ata_maint_pkg::OFF_SECCNT, ata_maint_pkg::OFF_SECNUM,
			ata_maint_pkg::OFF_CYL_LO, ata_maint_pkg::OFF_CYL_HI: begin
				read_value[7:0] = st.hob ? st.tf_prev[tf_index(a)] : st.tf_cur[tf_index(a)];
			end
			ata_maint_pkg::OFF_DEVHEAD:  read_value[7:0] = st.devhead;
			ata_maint_pkg::OFF_COMMAND: begin
				read_value[ata_maint_pkg::ST_BSY] = st.bsy;
				read_value[ata_maint_pkg::ST_RDY] = 1'b1;
				read_value[ata_maint_pkg::ST_DSC] = 1'b1;
				read_value[ata_maint_pkg::ST_DRQ] = st.drq;
				read_value[ata_maint_pkg::ST_ERR] = st.err_flag;
			end
			ata_maint_pkg::OFF_DEVCTL:   read_value[ata_maint_pkg::DEVCTL_HOB] = st.hob;
			ata_maint_pkg::OFF_CONFIG:   read_value[ata_maint_pkg::CFG_SPIN_DIS] = st.spin_dis;
			ata_maint_pkg::OFF_IRQ_STAT: read_value[1:0] = st.irq_stat;
			ata_maint_pkg::OFF_IRQ_MASK: read_value[1:0] = st.irq_mask;
			ata_maint_pkg::OFF_SEC_LEFT: read_value[15:0] = st.sec_left;
			default:                     read_value = 32'h0;
		endcase
	endfunction : read_value

	assign wr_fire = s.aw_got && s.w_got && !s.bvalid;
	assign cmd_go  = wr_fire && (s.aw_addr == ata_maint_pkg::OFF_COMMAND) && s.w_strb[0]
		&& (s.phase == ata_maint_pkg::PH_IDLE);
	assign data_go = wr_fire && (s.aw_addr == ata_maint_pkg::OFF_DATA) && s.drq
		&& (s.phase == ata_maint_pkg::PH_XFER);
	assign dl_len  = {s.tf_cur[ata_maint_pkg::TF_SECNUM], s.tf_cur[ata_maint_pkg::TF_SECCNT]};

	always_comb begin
		nxt              = s;
		ev               = 2'h0;
		nxt.diag_start   = 1'b0;
		nxt.reload_start = 1'b0;
		nxt.spin_down    = 1'b0;
		nxt.ucode_valid  = 1'b0;

		// Presence pin: three stages, change taken once the last two agree
		nxt.slv_sync = {s.slv_sync[1:0], i_slave_present};
		if (s.slv_sync[2] == s.slv_sync[1]) begin
			nxt.slv_stable = s.slv_sync[2];
		end

		// Read channel
		if (s.rvalid && i_rready) begin
			nxt.rvalid = 1'b0;
		end
		if (i_arvalid && s.arready) begin
			nxt.rvalid = 1'b1;
			nxt.rdata  = read_value(s, i_araddr);
			nxt.rresp  = addr_ok(i_araddr) ? ata_maint_pkg::RESP_OKAY : ata_maint_pkg::RESP_SLVERR;
		end
		nxt.arready = !nxt.rvalid;

		// Write channels, address and data taken in either order
		if (i_awvalid && s.awready) begin
			nxt.aw_got  = 1'b1;
			nxt.aw_addr = i_awaddr;
		end
		if (i_wvalid && s.wready) begin
			nxt.w_got  = 1'b1;
			nxt.w_data = i_wdata;
			nxt.w_strb = i_wstrb;
		end
		if (s.bvalid && i_bready) begin
			nxt.bvalid = 1'b0;
		end
		if (wr_fire) begin
			nxt.aw_got = 1'b0;
			nxt.w_got  = 1'b0;
			nxt.bvalid = 1'b1;
			nxt.bresp  = addr_ok(s.aw_addr) ? ata_maint_pkg::RESP_OKAY : ata_maint_pkg::RESP_SLVERR;
			case (s.aw_addr)
				ata_maint_pkg::OFF_FEATURE, ata_maint_pkg::OFF_SECCNT, ata_maint_pkg::OFF_SECNUM,
				ata_maint_pkg::OFF_CYL_LO, ata_maint_pkg::OFF_CYL_HI: begin
					// Task file is frozen while a command runs
					if (s.phase == ata_maint_pkg::PH_IDLE && s.w_strb[0]) begin
						nxt.tf_prev[tf_index(s.aw_addr)] = s.tf_cur[tf_index(s.aw_addr)];
						nxt.tf_cur[tf_index(s.aw_addr)]  = s.w_data[7:0];
						nxt.hob                          = 1'b0;
					end
				end
				ata_maint_pkg::OFF_DEVHEAD: begin
					if (s.phase == ata_maint_pkg::PH_IDLE && s.w_strb[0]) begin
						nxt.devhead = s.w_data[7:0];
					end
				end
				ata_maint_pkg::OFF_DEVCTL: begin
					if (s.w_strb[0]) begin
						nxt.hob = s.w_data[ata_maint_pkg::DEVCTL_HOB];
					end
				end
				ata_maint_pkg::OFF_CONFIG: begin
					if (s.w_strb[0]) begin
						nxt.spin_dis = s.w_data[ata_maint_pkg::CFG_SPIN_DIS];
					end
				end
				ata_maint_pkg::OFF_IRQ_STAT: begin
					if (s.w_strb[0]) begin
						nxt.irq_stat = s.irq_stat & ~s.w_data[1:0];
					end
				end
				ata_maint_pkg::OFF_IRQ_MASK: begin
					if (s.w_strb[0]) begin
						nxt.irq_mask = s.w_data[1:0];
					end
				end
				default: begin
				end
			endcase
		end
		nxt.awready = !nxt.aw_got && !nxt.bvalid;
		nxt.wready  = !nxt.w_got && !nxt.bvalid;

		// Command engine
		unique case (s.phase)
			ata_maint_pkg::PH_IDLE: begin
				if (cmd_go) begin
					nxt.err      = 8'h0;
					nxt.err_flag = 1'b0;
					if (s.w_data[7:0] == ata_maint_pkg::OP_DOWNLOAD) begin
						if (s.tf_cur[ata_maint_pkg::TF_FEATURE] != ata_maint_pkg::SUBCMD_SAVE
							|| i_security_locked) begin
							nxt.err[ata_maint_pkg::ERR_ABT] = 1'b1;
							nxt.err_flag                    = 1'b1;
							ev[ata_maint_pkg::EV_DONE]      = 1'b1;
						end else if (dl_len == 16'h0) begin
							ev[ata_maint_pkg::EV_DONE] = 1'b1;
						end else begin
							nxt.phase                 = ata_maint_pkg::PH_XFER;
							nxt.sec_left              = dl_len;
							nxt.word_cnt              = 7'h0;
							nxt.drq                   = 1'b1;
							ev[ata_maint_pkg::EV_DRQ] = 1'b1;
						end
					end else if (s.w_data[7:0] == ata_maint_pkg::OP_DIAG) begin
						nxt.phase      = ata_maint_pkg::PH_DIAG;
						nxt.bsy        = 1'b1;
						nxt.diag_start = 1'b1;
					end else if (s.w_data[7:0] == ata_maint_pkg::OP_FLUSH
						|| s.w_data[7:0] == ata_maint_pkg::OP_FLUSH_EXT) begin
						nxt.phase     = ata_maint_pkg::PH_FLUSH;
						nxt.bsy       = 1'b1;
						nxt.flush_req = 1'b1;
					end else begin
						nxt.err[ata_maint_pkg::ERR_ABT] = 1'b1;
						nxt.err_flag                    = 1'b1;
						ev[ata_maint_pkg::EV_DONE]      = 1'b1;
					end
				end
			end
			ata_maint_pkg::PH_XFER: begin
				if (data_go) begin
					nxt.ucode_data  = s.w_data;
					nxt.ucode_valid = 1'b1;
					if (s.word_cnt == ata_maint_pkg::WORD_LAST) begin
						nxt.drq      = 1'b0;
						nxt.word_cnt = 7'h0;
						nxt.sec_left = s.sec_left - 16'h1;
						if (s.sec_left == 16'h1) begin
							if (i_reload_requested) begin
								nxt.phase        = ata_maint_pkg::PH_RELOAD;
								nxt.bsy          = 1'b1;
								nxt.reload_start = 1'b1;
								nxt.dasp         = 1'b1;
								nxt.slave_lost   = 1'b1;
							end else begin
								nxt.phase                  = ata_maint_pkg::PH_IDLE;
								ev[ata_maint_pkg::EV_DONE] = 1'b1;
							end
						end
					end else begin
						nxt.word_cnt = s.word_cnt + 7'h1;
					end
				end else if (!s.drq) begin
					nxt.drq                   = 1'b1;
					ev[ata_maint_pkg::EV_DRQ] = 1'b1;
				end
			end
			ata_maint_pkg::PH_RELOAD: begin
				if (i_reload_done) begin
					nxt.phase                  = ata_maint_pkg::PH_IDLE;
					nxt.bsy                    = 1'b0;
					nxt.dasp                   = 1'b0;
					ev[ata_maint_pkg::EV_DONE] = 1'b1;
					if (!i_reload_ok) begin
						nxt.err[ata_maint_pkg::ERR_UNC] = 1'b1;
						nxt.err_flag                    = 1'b1;
					end
					nxt.spin_down = s.spin_dis;
				end
			end
			ata_maint_pkg::PH_DIAG: begin
				if (i_diag_done) begin
					nxt.err                    = i_diag_code;
					nxt.err_flag               = 1'b0;
					nxt.phase                  = ata_maint_pkg::PH_IDLE;
					nxt.bsy                    = 1'b0;
					ev[ata_maint_pkg::EV_DONE] = 1'b1;
				end
			end
			ata_maint_pkg::PH_FLUSH: begin
				if (i_flush_done) begin
					nxt.phase                  = ata_maint_pkg::PH_IDLE;
					nxt.bsy                    = 1'b0;
					nxt.flush_req              = 1'b0;
					ev[ata_maint_pkg::EV_DONE] = 1'b1;
					if (i_flush_fail) begin
						nxt.err[ata_maint_pkg::ERR_ABT] = 1'b1;
						nxt.err_flag                    = 1'b1;
					end
				end
			end
			default: begin
				nxt.phase = ata_maint_pkg::PH_IDLE;
				nxt.bsy   = 1'b0;
				nxt.drq   = 1'b0;
			end
		endcase

		// New events win over a clear in the same cycle
		nxt.irq_stat   = nxt.irq_stat | ev;
		nxt.irq        = |(nxt.irq_stat & nxt.irq_mask);
		nxt.slave_seen = nxt.slv_stable && !nxt.slave_lost;
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s <= '0;
		end else begin
			s <= nxt;
		end
	end

	assign o_awready        = s.awready;
	assign o_wready         = s.wready;
	assign o_bvalid         = s.bvalid;
	assign o_bresp          = s.bresp;
	assign o_arready        = s.arready;
	assign o_rvalid         = s.rvalid;
	assign o_rdata          = s.rdata;
	assign o_rresp          = s.rresp;
	assign o_irq            = s.irq;
	assign o_diag_start     = s.diag_start;
	assign o_flush_req      = s.flush_req;
	assign o_ucode_data     = s.ucode_data;
	assign o_ucode_valid    = s.ucode_valid;
	assign o_reload_start   = s.reload_start;
	assign o_spin_down      = s.spin_down;
	assign o_dasp_handshake = s.dasp;
	assign o_slave_seen     = s.slave_seen;

	property p_bad_sub;
		@(posedge i_clk) disable iff (!i_rst_n)
		cmd_go && s.w_data[7:0] == ata_maint_pkg::OP_DOWNLOAD
			&& s.tf_cur[ata_maint_pkg::TF_FEATURE] != ata_maint_pkg::SUBCMD_SAVE
		|=> s.err[ata_maint_pkg::ERR_ABT] && s.err_flag && !s.drq && s.phase == ata_maint_pkg::PH_IDLE;
	endproperty
	a_bad_sub: assert property (p_bad_sub) else $error("bad subcommand not aborted");

	property p_locked;
		@(posedge i_clk) disable iff (!i_rst_n)
		cmd_go && s.w_data[7:0] == ata_maint_pkg::OP_DOWNLOAD && i_security_locked
		|=> s.err[ata_maint_pkg::ERR_ABT] && !s.drq;
	endproperty
	a_locked: assert property (p_locked) else $error("locked download not aborted");

	property p_len;
		@(posedge i_clk) disable iff (!i_rst_n)
		cmd_go && s.w_data[7:0] == ata_maint_pkg::OP_DOWNLOAD && !i_security_locked
			&& s.tf_cur[ata_maint_pkg::TF_FEATURE] == ata_maint_pkg::SUBCMD_SAVE
		|=> (s.sec_left == $past(dl_len) && s.drq) or ($past(dl_len) == 16'h0 && !s.drq
			&& s.phase == ata_maint_pkg::PH_IDLE);
	endproperty
	a_len: assert property (p_len) else $error("download length or zero case wrong");

	property p_sector_end;
		@(posedge i_clk) disable iff (!i_rst_n)
		data_go && s.word_cnt == ata_maint_pkg::WORD_LAST && s.sec_left != 16'h1
		|=> !s.drq ##1 s.drq;
	endproperty
	a_sector_end: assert property (p_sector_end) else $error("per-sector request wrong");

	property p_unc;
		@(posedge i_clk) disable iff (!i_rst_n)
		s.phase == ata_maint_pkg::PH_RELOAD && i_reload_done
		|=> s.err[ata_maint_pkg::ERR_UNC] == !$past(i_reload_ok) && s.spin_down == $past(s.spin_dis);
	endproperty
	a_unc: assert property (p_unc) else $error("reload outcome misreported");

	property p_no_reload;
		@(posedge i_clk) disable iff (!i_rst_n)
		data_go && s.word_cnt == ata_maint_pkg::WORD_LAST && s.sec_left == 16'h1 && !i_reload_requested
		|=> !s.err[ata_maint_pkg::ERR_UNC] && !s.bsy;
	endproperty
	a_no_reload: assert property (p_no_reload) else $error("UNC without reload");

	property p_reload_slave;
		@(posedge i_clk) disable iff (!i_rst_n)
		s.phase == ata_maint_pkg::PH_RELOAD |-> s.dasp && s.bsy ##1 !s.slave_seen;
	endproperty
	a_reload_slave: assert property (p_reload_slave) else $error("second device seen after reload");

	property p_diag;
		@(posedge i_clk) disable iff (!i_rst_n)
		s.phase == ata_maint_pkg::PH_DIAG && i_diag_done |=> s.err == $past(i_diag_code) && !s.err_flag && !s.bsy;
	endproperty
	a_diag: assert property (p_diag) else $error("diagnostic code not stored");

	property p_flush;
		@(posedge i_clk) disable iff (!i_rst_n)
		s.phase == ata_maint_pkg::PH_FLUSH && !i_flush_done
		|=> s.phase == ata_maint_pkg::PH_FLUSH && s.bsy && s.flush_req;
	endproperty
	a_flush: assert property (p_flush) else $error("flush finished before cache written");

	property p_hob;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_arvalid && s.arready && i_araddr == ata_maint_pkg::OFF_SECCNT
		|=> s.rdata[7:0] == ($past(s.hob) ? $past(s.tf_prev[ata_maint_pkg::TF_SECCNT])
			: $past(s.tf_cur[ata_maint_pkg::TF_SECCNT]));
	endproperty
	a_hob: assert property (p_hob) else $error("HOB readback wrong");

	property p_status;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_arvalid && s.arready && i_araddr == ata_maint_pkg::OFF_COMMAND
		|=> s.rdata[7:0] == {$past(s.bsy), 3'h5, $past(s.drq), 2'h0, $past(s.err_flag)};
	endproperty
	a_status: assert property (p_status) else $error("status layout wrong");

	property p_error;
		@(posedge i_clk) disable iff (!i_rst_n)
		i_arvalid && s.arready && i_araddr == ata_maint_pkg::OFF_FEATURE |=> s.rdata[7:0] == $past(s.err);
	endproperty
	a_error: assert property (p_error) else $error("error readback wrong");

endmodule : ata_maint_command_handler

`default_nettype wire

// *** tb/drive_services_model.sv ***
// Behavioural drive services answering diagnostic, flush and reload requests
`timescale 1ns/100ps
`default_nettype none

module drive_services_model (
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst_n,
	// Requests from the handler
	input  wire logic       i_diag_start,
	input  wire logic       i_flush_req,
	input  wire logic       i_reload_start,
	// Bench knobs, delay at least one
	input  wire logic [7:0] i_delay,
	input  wire logic [7:0] i_code,
	input  wire logic       i_reload_fail,
	// Answers
	output logic            o_diag_done,
	output logic [7:0]      o_diag_code,
	output logic            o_flush_done,
	output logic            o_reload_done,
	output logic            o_reload_ok
);
	logic [7:0] cnt_ff;
	logic [2:0] kind_ff;

	// Results carry meaning only beside their done pulse
	assign o_diag_code = o_diag_done ? i_code : ~i_code;
	assign o_reload_ok = o_reload_done ? !i_reload_fail : i_reload_fail;

	// Diagnostic, cache commit and reload each take i_delay cycles before done
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_ff <= 8'h00;
			kind_ff <= 3'h0;
			{o_diag_done, o_flush_done, o_reload_done} <= 3'h0;
		end else begin
			{o_diag_done, o_flush_done, o_reload_done} <= 3'h0;
			if (cnt_ff != 8'h00) begin
				cnt_ff <= cnt_ff - 8'h01;
				if (cnt_ff == 8'h01) {o_diag_done, o_flush_done, o_reload_done} <= kind_ff;
			end else if (i_diag_start) begin
				cnt_ff <= i_delay;
				kind_ff <= 3'h4;
			end else if (i_flush_req && !o_flush_done) begin
				cnt_ff <= i_delay;
				kind_ff <= 3'h2;
			end else if (i_reload_start) begin
				cnt_ff <= i_delay;
				kind_ff <= 3'h1;
			end
		end
	end
endmodule : drive_services_model

`default_nettype wire

// *** tb/ata_maint_command_handler_tb.sv ***
// Register-level tests of the maintenance command handler
`timescale 1ns/100ps
`default_nettype none

module ata_maint_command_handler_tb;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00, dly = 8'h01, code = 8'h81;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, irq, lock = 1'b0, rel_req = 1'b0, rel_fail = 1'b0;
	logic [1:0]  bresp, rresp, bres;
	logic        ffail = 1'b0;
	logic [31:0] rdata, ucode;
	logic        dstart, ddone, freq, fdone, uvalid, rstart, rdone, rok, spin, dasp, seen;
	logic [7:0]  dcode;
	int          bad_count = 0, compares = 0, ucnt = 0, spins = 0, dasp_seen = 0;

	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		if (uvalid === 1'b1) begin
			chk(ucode, 32'(ucnt) ^ 32'ha5a5a5a5);
			ucnt++;
		end
		if (spin === 1'b1) spins++;
		if (dasp === 1'b1) dasp_seen = 1;
	end

	ata_maint_command_handler ata_maint_command_handler_inst (.i_clk(clk), .i_rst_n(rst_n),
		.i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf),
		.i_wvalid(wvalid), .o_wready(wready), .o_bvalid(bvalid), .o_bresp(bresp), .i_bready(bready),
		.i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready), .o_rvalid(rvalid), .o_rdata(rdata),
		.o_rresp(rresp), .i_rready(rready), .o_irq(irq), .i_security_locked(lock), .o_diag_start(dstart),
		.i_diag_done(ddone), .i_diag_code(dcode), .o_flush_req(freq), .i_flush_done(fdone), .i_flush_fail(ffail),
		.o_ucode_data(ucode), .o_ucode_valid(uvalid), .i_reload_requested(rel_req), .o_reload_start(rstart),
		.i_reload_done(rdone), .i_reload_ok(rok), .o_spin_down(spin), .o_dasp_handshake(dasp),
		.i_slave_present(1'b1), .o_slave_seen(seen));

	drive_services_model drive_services_model_inst (.i_clk(clk), .i_rst_n(rst_n), .i_diag_start(dstart),
		.i_flush_req(freq), .i_reload_start(rstart), .i_delay(dly), .i_code(code), .i_reload_fail(rel_fail),
		.o_diag_done(ddone), .o_diag_code(dcode), .o_flush_done(fdone), .o_reload_done(rdone), .o_reload_ok(rok));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bres = bresp;
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic rc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(d, exp);
	endtask : rc

	task automatic wait_idle;
		logic [31:0] d;
		logic [1:0]  r;
		do begin
			rd(ata_maint_pkg::OFF_COMMAND, d, r);
		end while (d[7] !== 1'b0);
	endtask : wait_idle

	task automatic cmd(input logic [7:0] f, input logic [7:0] c, input logic [7:0] s, input logic [7:0] op);
		wr(ata_maint_pkg::OFF_FEATURE, {24'h0, f});
		wr(ata_maint_pkg::OFF_SECCNT, {24'h0, c});
		wr(ata_maint_pkg::OFF_SECNUM, {24'h0, s});
		wr(ata_maint_pkg::OFF_COMMAND, {24'h0, op});
	endtask : cmd

	task automatic complete_run;
		$display("compares=%0d bad_count=%0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		complete_run();
	end

	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rc(ata_maint_pkg::OFF_COMMAND, 32'h50);
		cmd(8'h00, 8'h01, 8'h00, ata_maint_pkg::OP_DOWNLOAD);
		rc(ata_maint_pkg::OFF_FEATURE, 32'h04);
		rc(ata_maint_pkg::OFF_COMMAND, 32'h51);
		lock <= 1'b1;
		cmd(8'h07, 8'h01, 8'h00, ata_maint_pkg::OP_DOWNLOAD);
		rc(ata_maint_pkg::OFF_FEATURE, 32'h04);
		lock <= 1'b0;
		cmd(8'h07, 8'h00, 8'h00, ata_maint_pkg::OP_DOWNLOAD);
		rc(ata_maint_pkg::OFF_COMMAND, 32'h50);
		chk(32'(ucnt), 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(ata_maint_pkg::OFF_IRQ_MASK, 32'h1);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(ata_maint_pkg::OFF_IRQ_STAT, 32'h3);
		repeat (2) @(posedge clk);
		chk({31'h0, irq}, 32'h0);
		// One sector with a failing reload and spin-up disabled
		wr(ata_maint_pkg::OFF_CONFIG, 32'h1);
		rel_req <= 1'b1;
		rel_fail <= 1'b1;
		dly <= 8'h14;
		cmd(8'h07, 8'h01, 8'h00, ata_maint_pkg::OP_DOWNLOAD);
		rc(ata_maint_pkg::OFF_COMMAND, 32'h58);
		chk({31'h0, seen}, 32'h1);
		for (int i = 0; i < 128; i++) wr(ata_maint_pkg::OFF_DATA, 32'(i) ^ 32'ha5a5a5a5);
		wait_idle();
		rc(ata_maint_pkg::OFF_FEATURE, 32'h40);
		chk(32'(ucnt), 32'h80);
		chk(32'(spins), 32'h1);
		chk({31'h0, seen}, 32'h0);
		chk(32'(dasp_seen), 32'h1);
		// Two sectors with no reload asked
		rel_req <= 1'b0;
		rel_fail <= 1'b0;
		cmd(8'h07, 8'h02, 8'h00, ata_maint_pkg::OP_DOWNLOAD);
		for (int i = 128; i < 256; i++) wr(ata_maint_pkg::OFF_DATA, 32'(i) ^ 32'ha5a5a5a5);
		rc(ata_maint_pkg::OFF_SEC_LEFT, 32'h1);
		rc(ata_maint_pkg::OFF_COMMAND, 32'h58);
		for (int i = 256; i < 384; i++) wr(ata_maint_pkg::OFF_DATA, 32'(i) ^ 32'ha5a5a5a5);
		rc(ata_maint_pkg::OFF_FEATURE, 32'h00);
		rc(ata_maint_pkg::OFF_COMMAND, 32'h50);
		chk(32'(ucnt), 32'h180);
		chk(32'(spins), 32'h1);
		wr(ata_maint_pkg::OFF_COMMAND, 32'hff);
		rc(ata_maint_pkg::OFF_FEATURE, 32'h04);
		wr(ata_maint_pkg::OFF_COMMAND, {24'h0, ata_maint_pkg::OP_DIAG});
		wait_idle();
		rc(ata_maint_pkg::OFF_FEATURE, 32'h81);
		wr(ata_maint_pkg::OFF_COMMAND, {24'h0, ata_maint_pkg::OP_FLUSH});
		rc(ata_maint_pkg::OFF_COMMAND, 32'hd0);
		chk({31'h0, freq}, 32'h1);
		wait_idle();
		rc(ata_maint_pkg::OFF_COMMAND, 32'h50);
		wr(ata_maint_pkg::OFF_SECCNT, 32'h11);
		wr(ata_maint_pkg::OFF_SECCNT, 32'h22);
		wr(ata_maint_pkg::OFF_DEVCTL, 32'h80);
		rc(ata_maint_pkg::OFF_SECCNT, 32'h11);
		wr(ata_maint_pkg::OFF_DEVCTL, 32'h00);
		rc(ata_maint_pkg::OFF_SECCNT, 32'h22);
		wr(ata_maint_pkg::OFF_COMMAND, {24'h0, ata_maint_pkg::OP_FLUSH_EXT});
		rc(ata_maint_pkg::OFF_COMMAND, 32'hd0);
		wait_idle();
		rc(ata_maint_pkg::OFF_COMMAND, 32'h50);
		// Flush whose commit fails
		ffail <= 1'b1;
		wr(ata_maint_pkg::OFF_COMMAND, {24'h0, ata_maint_pkg::OP_FLUSH});
		wait_idle();
		rc(ata_maint_pkg::OFF_COMMAND, 32'h51);
		rc(ata_maint_pkg::OFF_FEATURE, 32'h04);
		ffail <= 1'b0;
		rd(8'h3c, d, r);
		chk({30'h0, r}, {30'h0, ata_maint_pkg::RESP_SLVERR});
		wr(8'h3c, 32'h0);
		chk({30'h0, bres}, {30'h0, ata_maint_pkg::RESP_SLVERR});
		cmd(8'h07, 8'h02, 8'h01, ata_maint_pkg::OP_DOWNLOAD);
		rc(ata_maint_pkg::OFF_SEC_LEFT, 32'h0102);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rc(ata_maint_pkg::OFF_COMMAND, 32'h50);
		repeat (3) @(posedge clk);
		chk({31'h0, seen}, 32'h1);
		complete_run();
	end
endmodule : ata_maint_command_handler_tb

`default_nettype wire
